//--- logic/otp_region_dev.sv
// Flash device end: overlay mode, region reads, buffered customer program, lock flags.
// Assumes array data returns combinationally from arr_addr, in the same cycle, on the same clock.
`timescale 1ns/1ps
`default_nettype none
// Operation
// [R1] Region reads served async and burst
// [R2] Overlay onto sector given at entry
// [R3] Burst in region wraps FFh to 00h
// [R4] Outside overlaid sector reads array data
// [R5] Refuse region while embedded/suspend/other overlay
// [R6] Factory lock reads zero, factory never programmed
// [R7] Customer lock reads one when delivered
// [R8] Customer word and lock set once only; here reset sets the lock back to one and clears the written flags
// [R9] Locked region program fails, reports protected
// [R10] Host enters with 0088h at sector+555h
// [R11] Overlay held until exit or reset
// [R12] Only reads, customer program, exit allowed
// [R13] Host programs 0025h, count, words, 0029h
// [R14] Buffer holds one to 32 words
// [R15] Host exits with 00F0h at base
// [R16] Customer lock zero blocks programming
// [R17] Other lock bits read one
// [R18] Other commands ignored in overlay
module otp_region_dev import otp_overlay_pkg::*; #(
  parameter logic [15:0] FACTORY_FILL = 16'h5A5A
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Link
  otp_link_if.dev link,
  // Array and embedded engine status
  output logic [15:0] arr_addr,
  input wire logic [15:0] arr_rdata,
  input wire logic emb_busy,
  input wire logic op_suspended,
  input wire logic other_overlay,
  // Lock request and status
  input wire logic lock_req,
  output logic [15:0] region_lock_flags,
  output logic in_overlay,
  output logic prog_done,
  output logic prog_protected
);
  dev_state_e state_ff, nxt_state;
  logic [3:0] sector_ff, nxt_sector;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [5:0] idx_ff, nxt_idx;
  logic [$clog2(PROG_CYCLES+1)-1:0] wait_ff, nxt_wait;
  logic [15:0] lock_ff, nxt_lock;
  logic [127:0] written_ff, nxt_written;
  logic fail_ff, nxt_fail;
  logic done_ff, nxt_done, prot_ff, nxt_prot;
  logic pend_ff, nxt_pend, hit_ff, nxt_hit;
  logic [15:0] hitdata_ff, nxt_hitdata, last_ff, nxt_last, arr_addr_ff, nxt_arr_addr;
  logic last_in_ff, nxt_last_in;
  logic rsp_valid_ff, nxt_rsp_valid;
  logic [15:0] rsp_data_ff, nxt_rsp_data;
  logic busy_ff, nxt_busy, ovl_ff, nxt_ovl;
  // Storage without reset
  logic [15:0] cust_mem [0:127];
  logic [7:0] buf_addr [0:BUF_WORDS-1];
  logic [15:0] buf_data [0:BUF_WORDS-1];
  logic buf_ok [0:BUF_WORDS-1];
  logic mem_we, buf_we, buf_ok_in;
  logic [6:0] mem_wa;
  logic [4:0] cur;
  logic blocked, rd_in, wr, rd;
  logic [15:0] eff_addr;

  // Region access refused while the engine or another overlay owns the part
  assign blocked = emb_busy | op_suspended | other_overlay | (state_ff == ST_RUN); // see [R5]
  assign wr = link.cmd_valid & link.cmd_write;
  assign rd = link.cmd_valid & ~link.cmd_write;
  assign cur = idx_ff[4:0];
  // Burst step wraps inside the region, runs on in the array
  always_comb begin
    if (link.cmd_burst) begin
      eff_addr = last_in_ff ? {last_ff[15:8], last_ff[7:0] + 8'h01} : last_ff + 16'h0001; // see [R3]
    end else begin
      eff_addr = link.cmd_addr; // see [R1]
    end
    rd_in = (state_ff != ST_IDLE) & ~blocked & (eff_addr[15:12] == sector_ff)
            & (eff_addr[11:8] == REGION_PAGE); // see [R2] [R4]
  end

  // Command decode, program engine and read pipeline
  always_comb begin
    nxt_state = state_ff;
    nxt_sector = sector_ff;
    nxt_cnt = cnt_ff;
    nxt_idx = idx_ff;
    nxt_wait = wait_ff;
    nxt_lock = lock_ff;
    nxt_written = written_ff;
    nxt_fail = fail_ff;
    nxt_done = 1'b0;
    nxt_prot = prot_ff;
    mem_we = 1'b0;
    mem_wa = buf_addr[cur][6:0];
    buf_we = 1'b0;
    buf_ok_in = (link.cmd_addr[15:12] == sector_ff) & (link.cmd_addr[11:8] == REGION_PAGE)
                & link.cmd_addr[REGION_CUST_BIT];
    // Read request: array address next cycle, answer two cycles later
    nxt_pend = rd;
    nxt_hit = rd & rd_in;
    nxt_arr_addr = rd ? eff_addr : arr_addr_ff;
    nxt_last = rd ? eff_addr : last_ff;
    nxt_last_in = rd ? rd_in : last_in_ff;
    if (~eff_addr[REGION_CUST_BIT]) begin
      nxt_hitdata = FACTORY_FILL;
    end else if (written_ff[eff_addr[6:0]]) begin
      nxt_hitdata = cust_mem[eff_addr[6:0]];
    end else begin
      nxt_hitdata = ERASED_WORD;
    end
    nxt_rsp_valid = pend_ff;
    nxt_rsp_data = pend_ff ? (hit_ff ? hitdata_ff : arr_rdata) : rsp_data_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (wr && !blocked && link.cmd_wdata == CMD_ENTER && link.cmd_addr[11:0] == OFF_UNLOCK) begin
          nxt_state = ST_OVL; // see [R10]
          nxt_sector = link.cmd_addr[15:12]; // see [R2]
        end
      end
      ST_OVL: begin
        // Only program setup, exit and lock_req act; all else ignored
        if (wr && link.cmd_wdata == CMD_EXIT) begin
          nxt_state = ST_IDLE; // see [R15]
        end else if (wr && link.cmd_wdata == CMD_PSETUP && link.cmd_addr[11:0] == OFF_UNLOCK
                     && link.cmd_addr[15:12] == sector_ff) begin
          nxt_state = ST_PCNT; // see [R12] [R13]
        end
        if (lock_req && !blocked) begin
          nxt_lock[LOCK_CUST_BIT] = 1'b0; // see [R8]
        end
      end
      ST_PCNT: begin
        if (wr) begin
          nxt_idx = 6'd0;
          if (link.cmd_wdata == CMD_EXIT) begin
            nxt_state = ST_IDLE;
          end else if (link.cmd_addr[11:0] == OFF_COUNT && link.cmd_wdata[15:5] == 11'h000) begin
            nxt_cnt = link.cmd_wdata[4:0]; // see [R14]
            nxt_state = ST_LOAD;
          end else begin
            nxt_state = ST_OVL; // see [R18]
          end
        end
      end
      ST_LOAD: begin
        if (wr) begin
          if (idx_ff <= {1'b0, cnt_ff}) begin
            buf_we = 1'b1; // see [R14]
            nxt_idx = idx_ff + 6'd1;
          end else if (link.cmd_wdata == CMD_PCONF && link.cmd_addr[11:0] == OFF_UNLOCK) begin
            nxt_state = ST_RUN; // see [R13]
            nxt_idx = 6'd0;
            nxt_wait = PROG_CYCLES[$bits(wait_ff)-1:0];
            nxt_fail = 1'b0;
          end else if (link.cmd_wdata == CMD_EXIT) begin
            nxt_state = ST_IDLE;
          end else begin
            nxt_state = ST_OVL; // see [R18]
          end
        end
      end
      ST_RUN: begin
        if (wait_ff != '0) begin
          nxt_wait = wait_ff - 1'b1;
        end else begin
          // One buffer word committed per cycle
          if (!buf_ok[cur] || !lock_ff[LOCK_CUST_BIT] || written_ff[mem_wa]) begin
            nxt_fail = 1'b1; // see [R6] [R8] [R9] [R16]
          end else begin
            mem_we = 1'b1;
            nxt_written[mem_wa] = 1'b1; // see [R8]
          end
          nxt_idx = idx_ff + 6'd1;
          if (idx_ff == {1'b0, cnt_ff}) begin
            nxt_state = ST_OVL; // see [R11]
            nxt_done = 1'b1;
            nxt_prot = nxt_fail; // see [R9]
          end
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    nxt_lock[LOCK_FACT_BIT] = 1'b0; // see [R6]
    nxt_busy = (nxt_state == ST_RUN);
    nxt_ovl = (nxt_state != ST_IDLE); // see [R11]
  end

  // State registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
      sector_ff <= 4'h0;
      cnt_ff <= 5'h00;
      idx_ff <= 6'h00;
      wait_ff <= '0;
      lock_ff <= LOCK_RESET; // see [R7] [R17]
      written_ff <= '0;
      fail_ff <= 1'b0;
      done_ff <= 1'b0;
      prot_ff <= 1'b0;
      pend_ff <= 1'b0;
      hit_ff <= 1'b0;
      hitdata_ff <= 16'h0000;
      last_ff <= 16'h0000;
      last_in_ff <= 1'b0;
      arr_addr_ff <= 16'h0000;
      rsp_valid_ff <= 1'b0;
      rsp_data_ff <= 16'h0000;
      busy_ff <= 1'b0;
      ovl_ff <= 1'b0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      sector_ff <= nxt_sector;
      cnt_ff <= nxt_cnt;
      idx_ff <= nxt_idx;
      wait_ff <= nxt_wait;
      lock_ff <= nxt_lock;
      written_ff <= nxt_written;
      fail_ff <= nxt_fail;
      done_ff <= nxt_done;
      prot_ff <= nxt_prot;
      pend_ff <= nxt_pend;
      hit_ff <= nxt_hit;
      hitdata_ff <= nxt_hitdata;
      last_ff <= nxt_last;
      last_in_ff <= nxt_last_in;
      arr_addr_ff <= nxt_arr_addr;
      rsp_valid_ff <= nxt_rsp_valid;
      rsp_data_ff <= nxt_rsp_data;
      busy_ff <= nxt_busy;
      ovl_ff <= nxt_ovl;
    end
  end

  // Write buffer and customer words
  always_ff @(posedge core_clk) begin
    if (clk_en && buf_we) begin
      buf_addr[cur] <= link.cmd_addr[7:0];
      buf_data[cur] <= link.cmd_wdata;
      buf_ok[cur] <= buf_ok_in;
    end
    if (clk_en && mem_we) begin
      cust_mem[mem_wa] <= buf_data[cur];
    end
  end

  // Outputs from flops
  assign link.rsp_valid = rsp_valid_ff;
  assign link.rsp_data = rsp_data_ff;
  assign link.dev_busy = busy_ff;
  assign arr_addr = arr_addr_ff;
  assign region_lock_flags = lock_ff;
  assign in_overlay = ovl_ff;
  assign prog_done = done_ff;
  assign prog_protected = prot_ff;
endmodule // otp_region_dev
`default_nettype wire

//--- logic/otp_overlay_pkg.sv
// Shared constants for the one-time-programmable region overlay ends.
// Assumes both ends share one clock and one active-low reset.
package otp_overlay_pkg;
  // Command data words
  localparam logic [15:0] CMD_ENTER = 16'h0088;
  localparam logic [15:0] CMD_PSETUP = 16'h0025;
  localparam logic [15:0] CMD_PCONF = 16'h0029;
  localparam logic [15:0] CMD_EXIT = 16'h00F0;
  // Word offsets inside a sector
  localparam logic [11:0] OFF_UNLOCK = 12'h555;
  localparam logic [11:0] OFF_COUNT = 12'h2AA;
  // Region layout: 256 words at the sector base, upper half customer
  localparam logic [3:0] REGION_PAGE = 4'h0;
  localparam int REGION_CUST_BIT = 7;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  // Write buffer depth in words
  localparam int BUF_WORDS = 32;
  // Lock flags: customer bit 0, factory bit 1, other bits read one
  localparam int LOCK_CUST_BIT = 0;
  localparam int LOCK_FACT_BIT = 1;
  localparam logic [15:0] LOCK_RESET = 16'hFFFD;
  // Embedded program time per operation
  localparam int PROG_TIME_NS = 2000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Device command states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OVL = 3'b001,
    ST_PCNT = 3'b010,
    ST_LOAD = 3'b011,
    ST_RUN = 3'b100
  } dev_state_e;
  // Host request kinds
  typedef enum logic [2:0] {
    OP_ENTER = 3'b000,
    OP_EXIT = 3'b001,
    OP_READ = 3'b010,
    OP_BURST = 3'b011,
    OP_PSETUP = 3'b100,
    OP_PWORD = 3'b101,
    OP_PCONF = 3'b110
  } host_op_e;
endpackage

//--- logic/otp_link_if.sv
// Command link between host controller and flash device end.
// Assumes both ends run on one clock; the testbench joins them.
`timescale 1ns/1ps
`default_nettype none
interface otp_link_if;
  logic cmd_valid;
  logic cmd_write;
  logic cmd_burst;
  logic [15:0] cmd_addr;
  logic [15:0] cmd_wdata;
  logic rsp_valid;
  logic [15:0] rsp_data;
  logic dev_busy;
  modport host (output cmd_valid, output cmd_write, output cmd_burst, output cmd_addr, output cmd_wdata,
                input rsp_valid, input rsp_data, input dev_busy);
  modport dev (input cmd_valid, input cmd_write, input cmd_burst, input cmd_addr, input cmd_wdata,
               output rsp_valid, output rsp_data, output dev_busy);
endinterface
`default_nettype wire

//--- logic/otp_region_host.sv
// Host controller end: turns user requests into flash command cycles.
// Assumes the device end shares the clock and answers reads two cycles later.
`timescale 1ns/1ps
`default_nettype none
module otp_region_host import otp_overlay_pkg::*; (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Link
  otp_link_if.host link,
  // User requests
  input wire logic req_valid,
  input wire logic [2:0] req_op,
  input wire logic [3:0] req_sector,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_data,
  output logic req_ready,
  // Read answers
  output logic rd_valid,
  output logic [15:0] rd_data
);
  logic second_ff, nxt_second;
  logic [4:0] count_ff, nxt_count;
  logic [3:0] sec_ff, nxt_sec;
  logic ready_ff, nxt_ready;
  logic cv_ff, nxt_cv, cw_ff, nxt_cw, cb_ff, nxt_cb;
  logic [15:0] ca_ff, nxt_ca, cd_ff, nxt_cd;
  logic rv_ff, nxt_rv;
  logic [15:0] rdat_ff, nxt_rdat;
  logic take;

  assign take = req_valid & ready_ff;
  // Command cycle generation
  always_comb begin
    nxt_second = 1'b0;
    nxt_count = count_ff;
    nxt_sec = sec_ff;
    nxt_cv = 1'b0;
    nxt_cw = 1'b1;
    nxt_cb = 1'b0;
    nxt_ca = ca_ff;
    nxt_cd = cd_ff;
    nxt_rv = link.rsp_valid;
    nxt_rdat = link.rsp_valid ? link.rsp_data : rdat_ff;
    if (second_ff) begin
      nxt_cv = 1'b1;
      nxt_ca = {sec_ff, OFF_COUNT}; // see [R13]
      nxt_cd = {11'h000, count_ff}; // see [R14]
    end else if (take) begin
      nxt_cv = 1'b1;
      unique case (host_op_e'(req_op))
        OP_ENTER: begin
          nxt_ca = {req_sector, OFF_UNLOCK}; // see [R10]
          nxt_cd = CMD_ENTER;
        end
        OP_EXIT: begin
          nxt_ca = 16'h0000; // see [R15]
          nxt_cd = CMD_EXIT;
        end
        OP_READ: begin
          nxt_cw = 1'b0;
          nxt_ca = req_addr;
        end
        OP_BURST: begin
          nxt_cw = 1'b0;
          nxt_cb = 1'b1;
        end
        OP_PSETUP: begin
          nxt_ca = {req_sector, OFF_UNLOCK}; // see [R13]
          nxt_cd = CMD_PSETUP;
          nxt_second = 1'b1;
          nxt_sec = req_sector;
          nxt_count = req_data[4:0]; // see [R14]
        end
        OP_PWORD: begin
          nxt_ca = req_addr;
          nxt_cd = req_data;
        end
        OP_PCONF: begin
          nxt_ca = {req_sector, OFF_UNLOCK}; // see [R13]
          nxt_cd = CMD_PCONF;
        end
        default: nxt_cv = 1'b0;
      endcase
    end
    // Hold off while a cycle pair runs or the device programs
    // A confirm on the link now raises busy next cycle, so stay low across it
    nxt_ready = ~nxt_second & ~take & ~second_ff & ~link.dev_busy & ~(cv_ff & cw_ff & (cd_ff == CMD_PCONF));
  end

  // Registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      second_ff <= 1'b0;
      count_ff <= 5'h00;
      sec_ff <= 4'h0;
      ready_ff <= 1'b0;
      cv_ff <= 1'b0;
      cw_ff <= 1'b0;
      cb_ff <= 1'b0;
      ca_ff <= 16'h0000;
      cd_ff <= 16'h0000;
      rv_ff <= 1'b0;
      rdat_ff <= 16'h0000;
    end else if (clk_en) begin
      second_ff <= nxt_second;
      count_ff <= nxt_count;
      sec_ff <= nxt_sec;
      ready_ff <= nxt_ready;
      cv_ff <= nxt_cv;
      cw_ff <= nxt_cw;
      cb_ff <= nxt_cb;
      ca_ff <= nxt_ca;
      cd_ff <= nxt_cd;
      rv_ff <= nxt_rv;
      rdat_ff <= nxt_rdat;
    end
  end

  assign link.cmd_valid = cv_ff;
  assign link.cmd_write = cw_ff;
  assign link.cmd_burst = cb_ff;
  assign link.cmd_addr = ca_ff;
  assign link.cmd_wdata = cd_ff;
  assign req_ready = ready_ff;
  assign rd_valid = rv_ff;
  assign rd_data = rdat_ff;
endmodule // otp_region_host
`default_nettype wire

//--- dv/otp_overlay_chk.sv
// Checker for the overlay command link and device status outputs.
// Assumes one clock domain; placed beside the link interface.
`timescale 1ns/1ps
`default_nettype none
module otp_overlay_chk import otp_overlay_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Link signals
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [15:0] cmd_addr,
  input wire logic [15:0] cmd_wdata,
  input wire logic rsp_valid,
  input wire logic dev_busy,
  // Device status
  input wire logic in_overlay,
  input wire logic prog_done,
  input wire logic prog_protected,
  input wire logic [15:0] region_lock_flags
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // Decoded command cycles
  logic is_rd, is_wr, is_enter, is_exit, is_conf;
  assign is_rd = cmd_valid && !cmd_write;
  assign is_wr = cmd_valid && cmd_write;
  assign is_enter = is_wr && cmd_wdata == CMD_ENTER && cmd_addr[11:0] == OFF_UNLOCK;
  assign is_exit = is_wr && cmd_wdata == CMD_EXIT;
  assign is_conf = is_wr && cmd_wdata == CMD_PCONF && cmd_addr[11:0] == OFF_UNLOCK;

  // Steps of a one-word program
  sequence s_setup;
    in_overlay && !dev_busy && is_wr && cmd_wdata == CMD_PSETUP && cmd_addr[11:0] == OFF_UNLOCK;
  endsequence
  sequence s_count_one;
    is_wr && cmd_wdata == 16'h0000 && cmd_addr[11:0] == OFF_COUNT;
  endsequence
  sequence s_word;
    is_wr && cmd_wdata != CMD_EXIT;
  endsequence

  AST_RD_LATENCY: assert property (is_rd |-> ##2 rsp_valid)
    else $error("read not answered two cycles later");
  AST_RSP_CAUSE: assert property (rsp_valid |-> $past(is_rd, 2))
    else $error("answer without a read two cycles before");
  AST_LOCK_FIXED: assert property ((region_lock_flags | 16'h0001) == 16'hFFFD)
    else $error("fixed lock flag bits wrong");
  AST_LOCK_ONCE: assert property (!region_lock_flags[0] |=> !region_lock_flags[0])
    else $error("customer lock cleared");
  AST_ENTER_CAUSE: assert property ($rose(in_overlay) |-> $past(is_enter))
    else $error("overlay entered without entry cycle");
  AST_EXIT_TAKEN: assert property (in_overlay && !dev_busy && is_exit |=> !in_overlay)
    else $error("exit cycle did not leave overlay");
  AST_HOLD_OVERLAY: assert property ($fell(in_overlay) |-> $past(is_exit))
    else $error("overlay left without exit cycle");
  AST_PROG_RUN: assert property (s_setup ##1 s_count_one ##[1:8] s_word ##[1:8] is_conf |=> dev_busy)
    else $error("program sequence did not start");
  AST_BUSY_CAUSE: assert property ($rose(dev_busy) |-> $past(is_conf))
    else $error("busy without confirm cycle");
  AST_RUN_BOUND: assert property ($rose(dev_busy) |-> ##[2:200] !dev_busy)
    else $error("program run did not end");
  AST_PROT_AT_DONE: assert property ($rose(prog_protected) |-> prog_done)
    else $error("protected status away from program end");
endmodule // otp_overlay_chk
`default_nettype wire

//--- dv/tb_otp_region_overlay_access.sv
// Testbench joining host and device ends through the command link.
// Assumes a 25 MHz clock and a combinational array model behind the device.
`timescale 1ns/1ps
`default_nettype none
module tb_otp_region_overlay_access import otp_overlay_pkg::*; ();
  logic core_clk, rst_b, clk_en, req_valid, emb_busy, op_suspended, other_overlay, lock_req;
  logic req_ready, rd_valid, in_overlay, prog_done, prog_protected;
  logic [2:0] req_op;
  logic [3:0] req_sector;
  logic [15:0] req_addr, req_data, arr_addr, arr_rdata, region_lock_flags, rd_data;
  int miscompares = 0;
  int checked = 0;

  // Clock and array model
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  assign arr_rdata = arr_addr ^ 16'h3C3C;

  otp_link_if u_otp_link_if ();
  otp_region_host u_otp_region_host (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .link(u_otp_link_if),
    .req_valid(req_valid), .req_op(req_op), .req_sector(req_sector), .req_addr(req_addr), .req_data(req_data),
    .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data));
  otp_region_dev #(.FACTORY_FILL(16'h5A5A)) u_otp_region_dev (.core_clk(core_clk), .rst_b(rst_b),
    .clk_en(clk_en), .link(u_otp_link_if), .arr_addr(arr_addr), .arr_rdata(arr_rdata), .emb_busy(emb_busy),
    .op_suspended(op_suspended), .other_overlay(other_overlay), .lock_req(lock_req),
    .region_lock_flags(region_lock_flags), .in_overlay(in_overlay), .prog_done(prog_done),
    .prog_protected(prog_protected));
  otp_overlay_chk u_otp_overlay_chk (.core_clk(core_clk), .rst_b(rst_b), .cmd_valid(u_otp_link_if.cmd_valid),
    .cmd_write(u_otp_link_if.cmd_write), .cmd_addr(u_otp_link_if.cmd_addr), .cmd_wdata(u_otp_link_if.cmd_wdata),
    .rsp_valid(u_otp_link_if.rsp_valid), .dev_busy(u_otp_link_if.dev_busy), .in_overlay(in_overlay),
    .prog_done(prog_done), .prog_protected(prog_protected), .region_lock_flags(region_lock_flags));

  // Verdict and end of run
  task automatic summarize();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One counted comparison
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Reset held for ten cycles
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask

  // Let a command reach the device
  task automatic settle();
    repeat (4) @(posedge core_clk);
  endtask

  // User request held until taken
  task automatic do_req(input logic [2:0] op, input logic [15:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_sector <= a[15:12];
    req_addr <= a;
    req_data <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 500);
    chk("req_ready", 16'h0001, {15'h0000, req_ready});
    req_valid <= 1'b0;
  endtask

  // Read or burst and compare the answer
  task automatic rd(input logic [2:0] op, input logic [15:0] a, input logic [15:0] exp);
    int n;
    n = 0;
    do_req(op, a, 16'h0000);
    while (rd_valid !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    chk("rd_valid", 16'h0001, {15'h0000, rd_valid});
    chk("rd_data", exp, rd_data);
  endtask

  // Wait for program end and compare protected status
  task automatic finish_prog(input logic prot);
    int n;
    n = 0;
    while (prog_done !== 1'b1 && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    chk("prog_done", 16'h0001, {15'h0000, prog_done});
    @(posedge core_clk);
    chk("prog_protected", {15'h0000, prot}, {15'h0000, prog_protected});
  endtask

  // One-word program
  task automatic prog(input logic [15:0] a, input logic [15:0] d, input logic prot);
    do_req(OP_PSETUP, a, 16'h0000);
    do_req(OP_PWORD, a, d);
    do_req(OP_PCONF, a, 16'h0000);
    finish_prog(prot);
  endtask

  // Main sequence
  initial begin
    clk_en = 1'b1;
    rst_b = 1'b0;
    req_valid = 1'b0;
    req_op = 3'h0;
    req_sector = 4'h0;
    req_addr = 16'h0000;
    req_data = 16'h0000;
    {emb_busy, op_suspended, other_overlay} = 3'h0;
    lock_req = 1'b0;
    do_reset();
    chk("lock_flags", 16'hFFFD, region_lock_flags);
    rd(OP_READ, 16'h3010, 16'h3010 ^ 16'h3C3C);
    for (int i = 0; i < 3; i++) begin
      {emb_busy, op_suspended, other_overlay} <= 3'h1 << i;
      do_req(OP_ENTER, 16'h3000, 16'h0000);
      settle();
      chk("in_overlay", 16'h0000, {15'h0000, in_overlay});
    end
    {emb_busy, op_suspended, other_overlay} <= 3'h0;
    do_req(OP_ENTER, 16'h3000, 16'h0000);
    settle();
    chk("in_overlay", 16'h0001, {15'h0000, in_overlay});
    rd(OP_READ, 16'h3080, ERASED_WORD);
    rd(OP_READ, 16'h3010, 16'h5A5A);
    rd(OP_READ, 16'h5010, 16'h5010 ^ 16'h3C3C);
    // Region read while another overlay owns the part gives array data
    other_overlay <= 1'b1;
    rd(OP_READ, 16'h3010, 16'h3010 ^ 16'h3C3C);
    other_overlay <= 1'b0;
    do_req(OP_PCONF, 16'h3000, 16'h0000);
    settle();
    chk("dev_busy", 16'h0003, {14'h0000, in_overlay, ~u_otp_link_if.dev_busy});
    do_req(OP_PSETUP, 16'h30A0, 16'h001F);
    for (int i = 0; i < 32; i++) begin
      do_req(OP_PWORD, 16'h30A0 + 16'(i), 16'h0100 + 16'(i));
    end
    do_req(OP_PCONF, 16'h30A0, 16'h0000);
    finish_prog(1'b0);
    rd(OP_READ, 16'h30BF, 16'h011F);
    rd(OP_READ, 16'h30A0, 16'h0100);
    rd(OP_BURST, 16'h0000, 16'h0101);
    prog(16'h30A0, 16'h0000, 1'b1);
    rd(OP_READ, 16'h30A0, 16'h0100);
    prog(16'h3010, 16'h0000, 1'b1);
    rd(OP_READ, 16'h30FF, ERASED_WORD);
    rd(OP_BURST, 16'h0000, 16'h5A5A);
    lock_req <= 1'b1;
    @(posedge core_clk);
    lock_req <= 1'b0;
    settle();
    chk("lock_flags", 16'hFFFC, region_lock_flags);
    prog(16'h3090, 16'h1111, 1'b1);
    rd(OP_READ, 16'h3090, ERASED_WORD);
    do_req(OP_EXIT, 16'h0000, 16'h0000);
    settle();
    chk("in_overlay", 16'h0000, {15'h0000, in_overlay});
    rd(OP_READ, 16'h3080, 16'h3080 ^ 16'h3C3C);
    do_req(OP_ENTER, 16'h5000, 16'h0000);
    settle();
    chk("in_overlay", 16'h0001, {15'h0000, in_overlay});
    do_reset();
    chk("in_overlay", 16'h0000, {15'h0000, in_overlay});
    chk("lock_flags", 16'hFFFD, region_lock_flags);
    summarize();
  end

  // Watchdog for a hung handshake
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    summarize();
  end
endmodule // tb_otp_region_overlay_access
`default_nettype wire
